// ===== verilog/cfg_regs_defs.svh
/*
  Register offsets, field positions and reset values for the converter
  configuration register slice. Assumes byte-wide register access.
*/
`ifndef CFG_REGS_DEFS_SVH
`define CFG_REGS_DEFS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFS_POS_0      8'h2C
`define OFS_POS_1      8'h2D
`define OFS_POS_2      8'h2E
`define OFS_FSR_0      8'h30
`define OFS_FSR_1      8'h31
`define OFS_PWR_1      8'h37
`define OFS_TSC        8'h3B
`define OFS_REFO       8'h3C

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RST_FSR        16'hA000
`define RST_PWR        8'h4B
`define RST_TSC        8'h00
`define RST_REFO       8'h01
`define PWR_LOW        8'h46
`define PWR_HIGH       8'h4B

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSC_RECV_BIT   0
`define TSC_PECL_BIT   1
`define REFO_EN_BIT    0
`define POS_BYTE0_LSB  0
`define POS_BYTE1_LSB  8
`define POS_BYTE2_LSB  16

`endif

// ===== verilog/cfg_regs_pkg.sv
/*
  Types shared by the configuration register slice.
  Assumes the defs header is included where constants are needed.
*/
package cfg_regs_pkg;

  typedef enum logic [1:0] {
    PWR_MODE_HIGH = 2'b01,
    PWR_MODE_LOW  = 2'b10
  } pwr_mode_t;

endpackage : cfg_regs_pkg

// ===== verilog/byte_reg.sv
/*
  One byte-wide read/write register with a reset value.
  Assumes write strobe and data from logic on the same clock.
*/
`timescale 1ns/1ps

module byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);

  logic [7:0] val_r;
  logic [7:0] val_nxt;

  always_comb begin
    val_nxt = val_r;
    if (wr_en) begin
      val_nxt = wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      val_r <= RESET_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign q = val_r;

endmodule : byte_reg

// ===== verilog/adc_config_status_regs.sv
/*
  Byte-addressed configuration and status registers: sync edge position,
  full-scale range, power mode, timestamp input control, reference clock
  output control. Assumes a serial port front end delivering single-cycle
  byte reads and writes on core_clk; sync_edge_position_in may come from
  another domain: it passes two flops and is taken only once it has held
  still for two edges.
*/
// Contract
// RL1: The 24-bit sync edge position is read-only status and writes never change it.
// RL2: Software reads the sync edge position to pick the sync delay choice value.
// RL3: The 16-bit full-scale code is read/write, shared by all channels, and resets to 0xA000.
// RL4: Software keeps the full-scale code at or above 0x2000; 0xFFFF is the maximum.
// RL5: The power mode code resets to 0x4B high performance, 0x46 is low power, others reserved.
// RL6: Software writes all four power mode registers together to the same mode.
// RL7: Software calibrates after any power mode change.
// RL8: Software clears calibration enable and serial link enable before writing power mode.
// RL9: Timestamp control bit 0, reset 0, enables the timestamp receiver.
// RL10: Timestamp control bit 1, reset 0, selects low-voltage PECL mode without self-bias.
// RL11: The reference output enable resets to 1 and drives the output whenever the PLL is on.
// RL12: Software writes reset defaults into reserved bit fields.
// RL13: Read/write registers return their last write or reset value; the position ignores writes.
`timescale 1ns/1ps
`include "cfg_regs_defs.svh"

module adc_config_status_regs
  import cfg_regs_pkg::*;
#(
  parameter int POS_W = 24
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_hit,
  input  wire logic [POS_W-1:0] sync_edge_position_in,
  input  wire logic             pll_on,
  output logic      [15:0]      full_scale_code,
  output logic      [7:0]       power_mode_code,
  output pwr_mode_t             power_mode,
  output logic                  power_mode_reserved,
  output logic                  timestamp_receiver_on,
  output logic                  timestamp_pecl_mode,
  output logic                  refclk_output_on,
  output logic                  refclk_output
);

  // ----------------------------------------
  // Position synchroniser
  // ----------------------------------------
  logic [POS_W-1:0] pos_meta_r;
  logic [POS_W-1:0] pos_meta_nxt;
  logic [POS_W-1:0] pos_sync_r;
  logic [POS_W-1:0] pos_sync_nxt;
  logic [POS_W-1:0] pos_prev_r;
  logic [POS_W-1:0] pos_prev_nxt;
  logic [POS_W-1:0] pos_hold_r;
  logic [POS_W-1:0] pos_hold_nxt;

  // Word taken only once equal on two edges, so no torn mix of bits
  always_comb begin
    pos_meta_nxt = sync_edge_position_in;
    pos_sync_nxt = pos_meta_r;
    pos_prev_nxt = pos_sync_r;
    pos_hold_nxt = pos_hold_r;
    if (pos_sync_r == pos_prev_r) begin
      pos_hold_nxt = pos_sync_r; // RL1
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos_meta_r <= '0;
      pos_sync_r <= '0;
      pos_prev_r <= '0;
      pos_hold_r <= '0;
    end else begin
      pos_meta_r <= pos_meta_nxt;
      pos_sync_r <= pos_sync_nxt;
      pos_prev_r <= pos_prev_nxt;
      pos_hold_r <= pos_hold_nxt;
    end
  end

  // ----------------------------------------
  // Position readback
  // ----------------------------------------
  logic [23:0] pos_word;

  always_comb begin
    pos_word = 24'(pos_hold_r); // RL1
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic we_fsr0;
  logic we_fsr1;
  logic we_pwr;
  logic we_tsc;
  logic we_refo;
  // Position bytes have no write enable

  always_comb begin
    we_fsr0 = reg_wr && (reg_addr == `OFS_FSR_0);
    we_fsr1 = reg_wr && (reg_addr == `OFS_FSR_1);
    we_pwr  = reg_wr && (reg_addr == `OFS_PWR_1);
    we_tsc  = reg_wr && (reg_addr == `OFS_TSC);
    we_refo = reg_wr && (reg_addr == `OFS_REFO);
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] fsr_lo;
  logic [7:0] fsr_hi;
  logic [7:0] pwr_q;
  logic [7:0] tsc_q;
  logic [7:0] refo_q;
  // Reserved bits are stored and read back as written

  byte_reg #(.RESET_VAL(8'(`RST_FSR))) u_fsr_lo ( // RL3
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (we_fsr0),
    .wr_data  (reg_wdata),
    .q        (fsr_lo)
  );

  byte_reg #(.RESET_VAL(8'(`RST_FSR >> 8))) u_fsr_hi ( // RL3
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (we_fsr1),
    .wr_data  (reg_wdata),
    .q        (fsr_hi)
  );

  byte_reg #(.RESET_VAL(`RST_PWR)) u_pwr ( // RL5
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (we_pwr),
    .wr_data  (reg_wdata),
    .q        (pwr_q)
  );

  byte_reg #(.RESET_VAL(`RST_TSC)) u_tsc ( // RL9
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (we_tsc),
    .wr_data  (reg_wdata),
    .q        (tsc_q)
  );

  byte_reg #(.RESET_VAL(`RST_REFO)) u_refo ( // RL11
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (we_refo),
    .wr_data  (reg_wdata),
    .q        (refo_q)
  );

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always_comb begin
    full_scale_code       = {fsr_hi, fsr_lo}; // RL3
    power_mode_code       = pwr_q;
    power_mode            = (pwr_q == `PWR_LOW) ? PWR_MODE_LOW : PWR_MODE_HIGH; // RL5
    power_mode_reserved   = (pwr_q != `PWR_LOW) && (pwr_q != `PWR_HIGH); // RL5
    timestamp_receiver_on = tsc_q[`TSC_RECV_BIT]; // RL9
    timestamp_pecl_mode   = tsc_q[`TSC_PECL_BIT]; // RL10
    refclk_output_on      = refo_q[`REFO_EN_BIT];
    refclk_output         = refo_q[`REFO_EN_BIT] && pll_on; // RL11
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       hit_r;
  logic       hit_nxt;
  // Read data holds between reads; unmapped reads give zero

  always_comb begin
    rdata_nxt = rdata_r;
    hit_nxt   = 1'b0;
    if (reg_rd) begin
      hit_nxt = 1'b1;
      unique case (reg_addr)
        `OFS_POS_0: rdata_nxt = pos_word[`POS_BYTE0_LSB +: 8]; // RL1
        `OFS_POS_1: rdata_nxt = pos_word[`POS_BYTE1_LSB +: 8]; // RL1
        `OFS_POS_2: rdata_nxt = pos_word[`POS_BYTE2_LSB +: 8]; // RL1
        `OFS_FSR_0: rdata_nxt = fsr_lo; // RL13
        `OFS_FSR_1: rdata_nxt = fsr_hi; // RL13
        `OFS_PWR_1: rdata_nxt = pwr_q; // RL13
        `OFS_TSC:   rdata_nxt = tsc_q; // RL13
        `OFS_REFO:  rdata_nxt = refo_q; // RL13
        default: begin
          rdata_nxt = 8'h00;
          hit_nxt   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      hit_r   <= hit_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_hit   = hit_r;

endmodule : adc_config_status_regs

// ===== test/adc_config_status_regs_properties.sv
/* Port checker for the configuration register slice.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module adc_config_status_regs_properties
  import cfg_regs_pkg::*;
#(
  parameter int POS_W = 24
) (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic [7:0]       reg_rdata,
  input wire logic             reg_hit,
  input wire logic [POS_W-1:0] sync_edge_position_in,
  input wire logic             pll_on,
  input wire logic [15:0]      full_scale_code,
  input wire logic [7:0]       power_mode_code,
  input wire pwr_mode_t        power_mode,
  input wire logic             power_mode_reserved,
  input wire logic             timestamp_receiver_on,
  input wire logic             timestamp_pecl_mode,
  input wire logic             refclk_output_on,
  input wire logic             refclk_output
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic mapped;
  logic fsr_wr;
  assign mapped = reg_addr inside {8'h2C, 8'h2D, 8'h2E, 8'h30, 8'h31, 8'h37, 8'h3B, 8'h3C};
  assign fsr_wr = reg_wr && (reg_addr inside {8'h30, 8'h31});
  sequence hit_rd;
    reg_rd && mapped;
  endsequence
  sequence miss_rd;
    reg_rd && !mapped;
  endsequence
  chk_fsr_low_wr: assert property (reg_wr && reg_addr == 8'h30 |=> full_scale_code[7:0] == $past(reg_wdata))
    else $error("full scale low byte not written");
  chk_fsr_high_wr: assert property (reg_wr && reg_addr == 8'h31 |=> full_scale_code[15:8] == $past(reg_wdata))
    else $error("full scale high byte not written");
  chk_fsr_hold: assert property (!fsr_wr |=> $stable(full_scale_code))
    else $error("full scale changed without write");
  chk_pwr_wr: assert property (reg_wr && reg_addr == 8'h37 |=> power_mode_code == $past(reg_wdata))
    else $error("power mode code not written");
  chk_pwr_decode: assert property (power_mode == (power_mode_code == 8'h46 ? PWR_MODE_LOW : PWR_MODE_HIGH))
    else $error("power mode decode wrong");
  chk_pwr_rsv: assert property (power_mode_reserved == !(power_mode_code inside {8'h46, 8'h4B}))
    else $error("reserved flag wrong");
  chk_tsc_bits: assert property (reg_wr && reg_addr == 8'h3B |=>
    {timestamp_pecl_mode, timestamp_receiver_on} == $past(reg_wdata[1:0]))
    else $error("timestamp control bits wrong");
  chk_refo_gate: assert property (refclk_output == (refclk_output_on && pll_on))
    else $error("reference output gating wrong");
  chk_hit_read: assert property (hit_rd |=> reg_hit ##1 (reg_hit == $past(reg_rd && mapped)))
    else $error("mapped read not acknowledged");
  chk_miss_read: assert property (miss_rd |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
endmodule : adc_config_status_regs_properties

// ===== test/adc_config_status_regs_test.sv
/* Self-checking bench for the configuration register slice.
   Assumes the checker file is compiled before this one. */
`timescale 1ns/1ps
module adc_config_status_regs_test;
  import cfg_regs_pkg::*;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pll_on = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pmc;
  logic [23:0] pos_in = 24'h123456;
  logic [15:0] fsc;
  pwr_mode_t pm;
  logic pmr, tsr, tsp, rfo, rfx, reg_hit;
  int error_cnt = 0, samples_checked = 0;
  logic [23:0] rows [9] = '{24'h305555, 24'h31C3C3,
                            24'h374646,
                            24'h3B0303, 24'h3C0000,
                            24'h2CFF56, 24'h2DFF34, 24'h2EFF12,
                            24'h40AA00};
  adc_config_status_regs #(.POS_W(24)) dut (
    .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .sync_edge_position_in(pos_in),
    .pll_on(pll_on), .full_scale_code(fsc), .power_mode_code(pmc), .power_mode(pm),
    .power_mode_reserved(pmr), .timestamp_receiver_on(tsr), .timestamp_pecl_mode(tsp),
    .refclk_output_on(rfo), .refclk_output(rfx));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 0;
  endtask : rd
  task automatic chk_rst;
    check(fsc, 16'hA000);
    check(pmc, 8'h4B);
    check({tsp, tsr}, 2'b00);
    check(rfo, 1'b1);
    check(rfx, pll_on);
    check(reg_rdata, 8'h00);
    check(reg_hit, 1'b0);
    $display("reset test done");
  endtask : chk_rst
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 0;
    chk_rst();
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      check(reg_rdata, rows[i][7:0]);
      check(reg_hit, rows[i][23:16] != 8'h40);
    end
    check(fsc, 16'hC355);
    check(pm, PWR_MODE_LOW);
    check({tsp, tsr}, 2'b11);
    check(rfx, 1'b0);
    $display("table test done");
    wr(8'h37, 8'h00);
    check(pmr, 1'b1);
    check(pm, PWR_MODE_HIGH);
    pll_on = 1;
    wr(8'h3C, 8'h01);
    check(rfx, 1'b1);
    pos_in = 24'hABCDEF;
    repeat (4) @(negedge core_clk);
    rd(8'h2E);
    check(reg_rdata, 8'hAB);
    $display("awkward test done");
    @(negedge core_clk);
    rst = 1;
    @(negedge core_clk);
    rst = 0;
    chk_rst();
    wrap_up();
  end
endmodule : adc_config_status_regs_test
bind adc_config_status_regs adc_config_status_regs_properties #(.POS_W(POS_W)) chk_i (
  .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .sync_edge_position_in(sync_edge_position_in), .pll_on(pll_on), .full_scale_code(full_scale_code),
  .power_mode_code(power_mode_code), .power_mode(power_mode), .power_mode_reserved(power_mode_reserved),
  .timestamp_receiver_on(timestamp_receiver_on), .timestamp_pecl_mode(timestamp_pecl_mode),
  .refclk_output_on(refclk_output_on), .refclk_output(refclk_output));
